// ===== rtl/icrc_engine.sv
// Purpose: interruptible crc-16 over a packed byte array in memory
// Assumes: classic wishbone slave, 32-bit data, synchronous reset
// Notes: one bit per clock; interrupts only between byte pairs
//
// Local design decisions: the register addresses and the Wishbone interface to the registers.
`timescale 1ns/1ps

// How it works
// - read words, earlier byte upper half
// - final check value left in accumulator
// - entry accumulator value seeds the crc
// - polynomial 100005 octal loaded each run
// - interrupt allowed after each byte pair
// - overflow set: resume from address, count
// - accumulator, address, count hold running state
// - entry tests overflow, loads poly, fetches
// - fresh start copies array address
// - first pair fetch sets overflow
// - zero count skips straight to completion
// - shift counter loaded with eight per byte
// - stall until memory signals fetch done
// - fetched word moves into operand register
// - shift, feed data bit, xor, undo
// - count zero clears overflow, advances pc
// - taken interrupt backs pc three words
module icrc_engine (
	input wire logic mclk,
	input wire logic reset,
	input wire logic ce,
	input wire logic [31:0] wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	input wire logic wb_we_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	output logic wb_ack_o,
	output logic wb_err_o,
	output logic irq,
	output logic mem_req_pin,
	output logic [15:0] mem_addr_pin,
	input wire logic mem_done_pin,
	input wire logic [15:0] mem_rdata_pin,
	input wire logic int_pending_pin
);
	import icrc_pkg::*;

	icrc_mem_if mif();
	icrc_state_t state;

	logic [15:0] accumulator;
	logic [15:0] addr_reg;
	logic [15:0] count_reg;
	logic [15:0] pc;
	logic [15:0] polynomial_register;
	logic [15:0] operand_holding_register;
	logic [3:0] shift_cnt;
	logic byte_sel;
	logic overflow;
	logic shifted_out_flag;
	logic req_q;
	logic [15:0] addr_q;
	logic [1:0] irq_stat;
	logic [1:0] irq_mask;
	logic int_s1;
	logic int_s2;

	icrc_mem_port u_port (
		.mclk(mclk),
		.reset(reset),
		.ce(ce),
		.mif(mif.port),
		.mem_req_pin(mem_req_pin),
		.mem_addr_pin(mem_addr_pin),
		.mem_done_pin(mem_done_pin),
		.mem_rdata_pin(mem_rdata_pin)
	);
	assign mif.req = req_q;
	assign mif.addr = addr_q;

	// ==========================================================
	// bus decode
	wire bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
	wire [7:0] ofs = wb_adr_i[7:0];
	wire known = (ofs <= OFS_POLY) && (ofs[1:0] == 2'h0) && (wb_adr_i[31:8] == 24'h000000);
	wire wr = bus_req & known & wb_we_i & wb_sel_i[0] & wb_sel_i[1];
	wire busy = (state != S_IDLE);
	wire wr_ctrl = wr & (ofs == OFS_CTRL);
	wire start = wr_ctrl & wb_dat_i[CTRL_START] & ~busy;
	wire wr_acc = wr & (ofs == OFS_ACC) & ~busy;
	wire wr_addr = wr & (ofs == OFS_ADDR) & ~busy;
	wire wr_cnt = wr & (ofs == OFS_COUNT) & ~busy;
	wire wr_pc = wr & (ofs == OFS_PC) & ~busy;
	wire wr_ovf = wr_ctrl & ~busy;
	wire wr_stat = wr & (ofs == OFS_IRQ_STAT);
	wire wr_mask = wr & (ofs == OFS_IRQ_MASK);
	wire [31:0] rd_mux =
		(ofs == OFS_ACC) ? {16'h0000, accumulator} :
		(ofs == OFS_ADDR) ? {16'h0000, addr_reg} :
		(ofs == OFS_COUNT) ? {16'h0000, count_reg} :
		(ofs == OFS_PC) ? {16'h0000, pc} :
		(ofs == OFS_STATUS) ? {30'h0, overflow, busy} :
		(ofs == OFS_IRQ_STAT) ? {30'h0, irq_stat} :
		(ofs == OFS_IRQ_MASK) ? {30'h0, irq_mask} :
		(ofs == OFS_POLY) ? {16'h0000, polynomial_register} : 32'h0000_0000;

	// ==========================================================
	// crc step datapath
	// shift and feedback
	wire old_top = accumulator[15];
	wire [15:0] shifted = {accumulator[14:0], operand_holding_register[15]};
	wire [15:0] crc_step = shifted ^ polynomial_register;
	wire [15:0] crc_next = old_top ? crc_step : shifted; // undo folded into one cycle
	wire [15:0] count_dec = count_reg - 16'h0001;
	wire last_bit = (shift_cnt == 4'h1);
	logic ctrl_int_block;
	wire int_now = int_s2 & ~ctrl_int_block;

	// ack one cycle after request; unmapped answers err
	always_ff @(posedge mclk) begin
		if (reset) begin
			wb_ack_o <= 1'b0;
			wb_err_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else if (ce) begin
			wb_ack_o <= bus_req & known;
			wb_err_o <= bus_req & ~known;
			wb_dat_o <= rd_mux;
		end
	end

	// interrupt pending pin synchroniser, caller's mask bit
	always_ff @(posedge mclk) begin
		if (reset) begin
			int_s1 <= 1'b0;
			int_s2 <= 1'b0;
			ctrl_int_block <= 1'b0;
		end else if (ce) begin
			int_s1 <= int_pending_pin;
			int_s2 <= int_s1;
			if (wr_ctrl) begin
				ctrl_int_block <= ~wb_dat_i[CTRL_INT_REQ];
			end
		end
	end

	// ==========================================================
	// engine sequencer
	// flow: idle, address fetch, count fetch, pair fetch, eight shifts,
	// byte end, second byte, then next pair, pause or done.
	// a paused run keeps overflow high so the next start resumes from
	// the held address and count rather than the caller's words.
	// pc only moves at the end of a run or at a pause, so a read
	// mid-run still shows where the caller's instruction sits.
	// bus writes to the working registers are refused while busy,
	// which keeps the sequencer their only writer during a run.
	// the undo of the polynomial fold is merged into the shift cycle:
	// one clock per bit, traded for never showing the folded value.
	// a fetch is one pulse on req_q; the port holds the pin until the
	// synchronised done edge, so the sequencer never asks twice.
	always_ff @(posedge mclk) begin
		if (reset) begin
			state <= S_IDLE;
			accumulator <= RST_WORD;
			addr_reg <= RST_WORD;
			count_reg <= RST_WORD;
			pc <= RST_WORD;
			polynomial_register <= RST_WORD;
			operand_holding_register <= RST_WORD;
			shift_cnt <= 4'h0;
			byte_sel <= 1'b0;
			overflow <= 1'b0;
			shifted_out_flag <= 1'b0;
			req_q <= 1'b0;
			addr_q <= RST_WORD;
		end else if (ce) begin
			req_q <= 1'b0;
			if (wr_acc) accumulator <= wb_dat_i[15:0];
			if (wr_addr) addr_reg <= wb_dat_i[15:0];
			if (wr_cnt) count_reg <= wb_dat_i[15:0];
			if (wr_pc) pc <= wb_dat_i[15:0];
			// caller's reset-overflow step before issuing the instruction
			if (wr_ovf) overflow <= wb_dat_i[CTRL_OVFL];
			unique case (state)
			S_IDLE: begin
				if (start) begin
					operand_holding_register <= CRC_POLY;
					if (wb_dat_i[CTRL_OVFL] | overflow) begin
						polynomial_register <= CRC_POLY;
						req_q <= 1'b1;
						addr_q <= addr_reg;
						state <= S_PAIR_WAIT;
					end else begin
						req_q <= 1'b1;
						addr_q <= pc + 16'h0001;
						state <= S_ADDR_WAIT;
					end
				end
			end
			S_ADDR_WAIT: begin
				if (mif.done) begin
					addr_reg <= mif.rdata;
					req_q <= 1'b1;
					addr_q <= pc + 16'h0002;
					state <= S_CNT_WAIT;
				end
			end
			S_CNT_WAIT: begin
				if (mif.done) begin
					count_reg <= mif.rdata;
					polynomial_register <= operand_holding_register;
					if (mif.rdata == RST_WORD) begin
						state <= S_DONE;
					end else begin
						overflow <= 1'b1;
						req_q <= 1'b1;
						addr_q <= addr_reg;
						state <= S_PAIR_WAIT;
					end
				end
			end
			S_PAIR_WAIT: begin
				if (mif.done) begin
					operand_holding_register <= mif.rdata;
					shift_cnt <= BITS_PER_BYTE;
					byte_sel <= 1'b0;
					state <= (count_reg == RST_WORD) ? S_DONE : S_SHIFT;
				end
			end
			S_SHIFT: begin
				accumulator <= crc_next;
				shifted_out_flag <= old_top;
				operand_holding_register <= {operand_holding_register[14:0], 1'b0};
				shift_cnt <= shift_cnt - 4'h1;
				if (last_bit) state <= S_BYTE_END;
			end
			S_BYTE_END: begin
				count_reg <= count_dec;
				if (count_dec == RST_WORD) begin
					state <= S_DONE;
				end else if (!byte_sel) begin
					byte_sel <= 1'b1;
					shift_cnt <= BITS_PER_BYTE;
					state <= S_SHIFT;
				end else begin
					addr_reg <= addr_reg + 16'h0001;
					if (int_now) begin
						pc <= pc - PC_BACKUP;
						state <= S_IDLE;
					end else begin
						req_q <= 1'b1;
						addr_q <= addr_reg + 16'h0001;
						state <= S_PAIR_WAIT;
					end
				end
			end
			S_DONE: begin
				overflow <= 1'b0;
				pc <= pc + PC_BACKUP;
				state <= S_IDLE;
			end
			default: state <= S_IDLE;
			endcase
		end
	end

	// ==========================================================
	// interrupt status, write one to clear, set wins
	// an event in the cycle of its own clear stays set, so none is lost
	wire [1:0] ev;
	assign ev[EV_DONE] = (state == S_DONE);
	assign ev[EV_INTR] = (state == S_BYTE_END) & byte_sel & int_now & (count_dec != RST_WORD);
	always_ff @(posedge mclk) begin
		if (reset) begin
			irq_stat <= RST_IRQ;
			irq_mask <= RST_IRQ;
			irq <= 1'b0;
		end else if (ce) begin
			irq_stat <= ev | (irq_stat & ~(wr_stat ? wb_dat_i[1:0] : 2'h0));
			if (wr_mask) irq_mask <= wb_dat_i[1:0];
			irq <= |(irq_stat & irq_mask);
		end
	end

endmodule : icrc_engine

// ===== pkg/icrc_pkg.sv
// Purpose: shared constants and types for the interruptible crc engine
// Assumes: 16-bit processor words, single 200 MHz clock
// Notes: bus offsets are word aligned byte addresses
package icrc_pkg;

	// ==========================================================
	// crc and shifting
	localparam logic [15:0] CRC_POLY = 16'h8005;
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;
	localparam logic [15:0] PC_BACKUP = 16'h0003;

	// ==========================================================
	// register offsets (byte addresses)
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_ACC = 8'h04;
	localparam logic [7:0] OFS_ADDR = 8'h08;
	localparam logic [7:0] OFS_COUNT = 8'h0c;
	localparam logic [7:0] OFS_PC = 8'h10;
	localparam logic [7:0] OFS_STATUS = 8'h14;
	localparam logic [7:0] OFS_IRQ_STAT = 8'h18;
	localparam logic [7:0] OFS_IRQ_MASK = 8'h1c;
	localparam logic [7:0] OFS_POLY = 8'h20;

	// ==========================================================
	// field positions
	localparam int CTRL_START = 0;
	localparam int CTRL_OVFL = 1;
	localparam int CTRL_INT_REQ = 2;
	localparam int ST_BUSY = 0;
	localparam int ST_OVFL = 1;
	localparam int EV_DONE = 0;
	localparam int EV_INTR = 1;

	// ==========================================================
	// reset values
	localparam logic [15:0] RST_WORD = 16'h0000;
	localparam logic [1:0] RST_IRQ = 2'h0;

	// engine states
	typedef enum logic [3:0] {
		S_IDLE, S_ADDR_REQ, S_ADDR_WAIT, S_CNT_REQ, S_CNT_WAIT,
		S_PAIR_REQ, S_PAIR_WAIT, S_SHIFT, S_BYTE_END, S_DONE
	} icrc_state_t;

endpackage : icrc_pkg

// ===== pkg/icrc_mem_if.sv
// Purpose: fetch request and answer between engine and memory port
// Assumes: one outstanding fetch at a time
// Notes: done is a one-cycle pulse carrying the fetched word
`timescale 1ns/1ps
interface icrc_mem_if;
	logic req;
	logic [15:0] addr;
	logic done;
	logic [15:0] rdata;
	modport engine (output req, output addr, input done, input rdata);
	modport port (input req, input addr, output done, output rdata);
endinterface : icrc_mem_if

// ===== rtl/icrc_mem_port.sv
// Purpose: registers fetch requests onto memory pins, synchronises done
// Assumes: memory holds rdata stable while mem_done_pin is high
// Notes: all pin outputs come from flip-flops
`timescale 1ns/1ps
module icrc_mem_port (
	input wire logic mclk,
	input wire logic reset,
	input wire logic ce,
	icrc_mem_if.port mif,
	output logic mem_req_pin,
	output logic [15:0] mem_addr_pin,
	input wire logic mem_done_pin,
	input wire logic [15:0] mem_rdata_pin
);
	import icrc_pkg::*;

	logic done_s1;
	logic done_s2;
	logic done_s3;
	logic [15:0] memory_input_word;
	wire done_rise = done_s2 & ~done_s3;

	// ==========================================================
	// request hold: stays up until the done edge is seen
	always_ff @(posedge mclk) begin
		if (reset) begin
			mem_req_pin <= 1'b0;
			mem_addr_pin <= RST_WORD;
		end else if (ce) begin
			if (mif.req) begin
				mem_req_pin <= 1'b1;
				mem_addr_pin <= mif.addr;
			end else if (done_rise) begin
				mem_req_pin <= 1'b0;
			end
		end
	end

	// two-stage synchroniser, third stage only for the edge
	always_ff @(posedge mclk) begin
		if (reset) begin
			done_s1 <= 1'b0;
			done_s2 <= 1'b0;
			done_s3 <= 1'b0;
			memory_input_word <= RST_WORD;
		end else if (ce) begin
			done_s1 <= mem_done_pin;
			done_s2 <= done_s1;
			done_s3 <= done_s2;
			// data is stable by the time the synchronised done shows
			if (done_rise) begin
				memory_input_word <= mem_rdata_pin;
			end
		end
	end

	// answer one cycle after the edge, with the captured word
	logic done_q;
	always_ff @(posedge mclk) begin
		if (reset) begin
			done_q <= 1'b0;
		end else if (ce) begin
			done_q <= done_rise & mem_req_pin;
		end
	end
	assign mif.done = done_q;
	assign mif.rdata = memory_input_word;

endmodule : icrc_mem_port

// ===== tb/icrc_mem_model.sv
// Purpose: word memory answering the engine fetch pins
// Assumes: one fetch outstanding, lat sets the answer delay
// Notes: rdata toggles while done is low so stale data never looks valid
`timescale 1ns/1ps
module icrc_mem_model (
	input wire logic mclk,
	input wire logic reset,
	input wire logic mem_req_pin,
	input wire logic [15:0] mem_addr_pin,
	output logic mem_done_pin,
	output logic [15:0] mem_rdata_pin
);
	// ==========================================================
	// storage and answer timing
	logic [15:0] mem [0:65535];
	int lat = 1;
	int waited = 0;
	// every word differs, so a wrong address shows in the crc
	initial for (int i = 0; i < 65536; i++) mem[i] = 16'(i * 40503 + 7);
	always @(posedge mclk) begin
		if (reset || !mem_req_pin || waited < lat) begin
			mem_done_pin <= 1'b0;
			mem_rdata_pin <= reset ? 16'h5a5a : ~mem_rdata_pin;
			waited <= mem_req_pin && !reset ? waited + 1 : 0;
		end else begin
			mem_done_pin <= 1'b1;
			mem_rdata_pin <= mem[mem_addr_pin];
		end
	end
endmodule : icrc_mem_model

// ===== tb/icrc_engine_sva.sv
// Purpose: handshake checks at the crc engine ports
// Assumes: one clock, synchronous active high reset
// Notes: bound into every engine instance
`timescale 1ns/1ps
module icrc_engine_sva (
	input wire logic mclk,
	input wire logic reset,
	input wire logic ce,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_ack_o,
	input wire logic wb_err_o,
	input wire logic mem_req_pin,
	input wire logic [15:0] mem_addr_pin,
	input wire logic mem_done_pin
);
	// ==========================================================
	// bus and fetch handshakes
	default clocking @(posedge mclk); endclocking
	// a low clock enable freezes the engine, so no timing holds then
	default disable iff (reset || !ce);
	sequence s_ask; wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o; endsequence
	sequence s_ans; wb_ack_o || wb_err_o; endsequence
	sequence s_got; mem_req_pin && mem_done_pin; endsequence
	property p_answer; s_ask |=> wb_ack_o || wb_err_o; endproperty
	property p_cause; s_ans |-> $past(wb_cyc_i && wb_stb_i); endproperty
	property p_pulse; s_ans |=> !wb_ack_o && !wb_err_o; endproperty
	property p_excl; !(wb_ack_o && wb_err_o); endproperty
	property p_hold; mem_req_pin && !mem_done_pin |=> mem_req_pin; endproperty
	property p_stable; mem_req_pin && $past(mem_req_pin) |-> $stable(mem_addr_pin); endproperty
	property p_release; s_got |-> ##[1:8] !mem_req_pin; endproperty
	property p_gap; $fell(mem_req_pin) |=> !mem_req_pin; endproperty
	a_answer: assert property (p_answer) else $error("bus request unanswered");
	a_cause: assert property (p_cause) else $error("answer without request");
	a_pulse: assert property (p_pulse) else $error("answer longer than a cycle");
	a_excl: assert property (p_excl) else $error("ack and err together");
	a_hold: assert property (p_hold) else $error("fetch dropped early");
	a_stable: assert property (p_stable) else $error("fetch address moved");
	a_release: assert property (p_release) else $error("fetch kept after done");
	a_gap: assert property (p_gap) else $error("fetches back to back");
endmodule : icrc_engine_sva

bind icrc_engine icrc_engine_sva icrc_engine_sva_i (.mclk(mclk), .reset(reset), .ce(ce),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o),
	.mem_req_pin(mem_req_pin), .mem_addr_pin(mem_addr_pin), .mem_done_pin(mem_done_pin));

// ===== tb/tb.sv
// Purpose: self-checking bench for the crc engine
// Assumes: classic bus master, memory model on the fetch pins
// Notes: expected crc is rebuilt here bit by bit
`timescale 1ns/1ps
module tb;
	import icrc_pkg::*;
	// ==========================================================
	// signals and instances
	localparam logic [15:0] POLY = 16'h8005;
	logic mclk = 0, reset = 1, ce = 1, wb_we_i = 0, wb_cyc_i = 0, wb_stb_i = 0;
	logic int_pending_pin = 0, wb_ack_o, wb_err_o, irq, mem_req_pin, mem_done_pin, berr;
	logic [3:0] wb_sel_i = 4'hf;
	logic [31:0] wb_adr_i = '0, wb_dat_i = '0, wb_dat_o, rd;
	logic [15:0] mem_addr_pin, mem_rdata_pin;
	int mismatches = 0, n_checks = 0, ticks = 0;
	icrc_engine icrc_engine_i (.mclk, .reset, .ce, .wb_adr_i, .wb_dat_i, .wb_dat_o,
		.wb_we_i, .wb_sel_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .wb_err_o, .irq,
		.mem_req_pin, .mem_addr_pin, .mem_done_pin, .mem_rdata_pin, .int_pending_pin);
	icrc_mem_model icrc_mem_model_i (.mclk, .reset, .mem_req_pin, .mem_addr_pin,
		.mem_done_pin, .mem_rdata_pin);
	// clock and hang guard
	initial forever #2.5 mclk = ~mclk;
	always @(posedge mclk) begin
		ticks++;
		if (ticks == 20000) begin
			mismatches++;
			test_done;
		end
	end
	// ==========================================================
	// shared tasks
	task automatic test_done;
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : test_done
	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
		n_checks++;
		if (s !== e) begin
			mismatches++;
			$display("unexpected %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	// classic cycle, entered an edge late so cyc idles one cycle
	task automatic bus(input logic w, input logic [7:0] a, input logic [15:0] d);
		@(posedge mclk);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= w;
		wb_adr_i <= {24'h0, a};
		wb_dat_i <= {16'h0, d};
		do @(posedge mclk); while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1);
		rd = wb_dat_o;
		berr = wb_err_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask : bus
	task automatic rdchk(input logic [7:0] a, input logic [15:0] e, input string n);
		bus(1'b0, a, 16'h0);
		chk(n, e, rd[15:0]);
	endtask : rdchk
	task automatic run(input logic [15:0] c);
		bus(1'b1, OFS_CTRL, c);
		do bus(1'b0, OFS_STATUS, 16'h0); while (rd[ST_BUSY] !== 1'b0);
	endtask : run
	// caller words follow the instruction at 0x0100
	task automatic prog(input logic [15:0] acc, input logic [15:0] n);
		icrc_mem_model_i.mem[16'h0101] = 16'h0200;
		icrc_mem_model_i.mem[16'h0102] = n;
		bus(1'b1, OFS_ACC, acc);
		bus(1'b1, OFS_PC, 16'h0100);
	endtask : prog
	// upper byte first, msb first, feedback when the old top bit is set
	function automatic logic [15:0] crc(input logic [15:0] a, input int n);
		logic [15:0] w;
		for (int i = 0; i < n; i++) begin
			w = icrc_mem_model_i.mem[16'h0200 + i / 2] << (i % 2 * 8);
			for (int k = 15; k > 7; k--) a = {a[14:0], w[k]} ^ (a[15] ? POLY : 16'h0);
		end
		return a;
	endfunction : crc
	// ==========================================================
	// scenarios
	task automatic t_full;
		prog(16'h1234, 16'h0005);
		bus(1'b1, OFS_CTRL, 16'h0001);
		// freeze mid-fetch: the request must stand still while ce is low
		ce <= 1'b0;
		repeat (40) @(posedge mclk);
		chk("frozen req", 16'h0001, {15'h0, mem_req_pin});
		chk("frozen addr", 16'h0101, mem_addr_pin);
		ce <= 1'b1;
		do bus(1'b0, OFS_STATUS, 16'h0); while (rd[ST_BUSY] !== 1'b0);
		rdchk(OFS_ACC, crc(16'h1234, 5), "acc");
		rdchk(OFS_PC, 16'h0103, "pc");
		rdchk(OFS_STATUS, 16'h0000, "status");
		rdchk(OFS_POLY, POLY, "poly");
		rdchk(OFS_IRQ_STAT, 16'h0001, "irq_stat");
		chk("irq masked", 16'h0, {15'h0, irq});
		bus(1'b1, OFS_IRQ_MASK, 16'h0001);
		bus(1'b0, 8'h24, 16'h0);
		chk("unmapped err", 16'h1, {15'h0, berr});
		chk("irq", 16'h1, {15'h0, irq});
		bus(1'b1, OFS_IRQ_STAT, 16'h0001);
		rdchk(OFS_IRQ_STAT, 16'h0000, "irq_stat clear");
		chk("irq clear", 16'h0, {15'h0, irq});
	endtask : t_full
	// slow memory, interrupt after the first pair, resume from registers
	task automatic t_intr;
		icrc_mem_model_i.lat = 6;
		int_pending_pin <= 1'b1;
		prog(16'h0000, 16'h0006);
		run(16'h0005);
		rdchk(OFS_STATUS, 16'h0002, "paused status");
		rdchk(OFS_COUNT, 16'h0004, "count");
		rdchk(OFS_ADDR, 16'h0201, "addr");
		rdchk(OFS_ACC, crc(16'h0000, 2), "paused acc");
		rdchk(OFS_PC, 16'h00fd, "paused pc");
		rdchk(OFS_IRQ_STAT, 16'h0002, "irq_stat intr");
		chk("irq masked", 16'h0, {15'h0, irq});
		int_pending_pin <= 1'b0;
		bus(1'b1, OFS_IRQ_STAT, 16'h0002);
		icrc_mem_model_i.mem[16'h0102] = 16'h0000;
		run(16'h0003);
		rdchk(OFS_ACC, crc(16'h0000, 6), "resumed acc");
		rdchk(OFS_PC, 16'h0100, "resumed pc");
		rdchk(OFS_STATUS, 16'h0000, "resumed status");
	endtask : t_intr
	task automatic t_zero;
		prog(16'hbeef, 16'h0000);
		run(16'h0001);
		rdchk(OFS_ACC, 16'hbeef, "zero acc");
		rdchk(OFS_PC, 16'h0103, "zero pc");
	endtask : t_zero
	initial begin
		repeat (3) @(posedge mclk);
		reset <= 1'b0;
		t_full;
		t_intr;
		t_zero;
		test_done;
	end
endmodule : tb
